// ==== interlock_pkg.sv ====
// interlock_pkg: register map, field layout, reset values and timing counts
// assumes a 20 MHz ref_clk; all counts derive from that rate
package interlock_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
	// response time = base + per-scan * scans
	localparam int unsigned RESP_BASE_MS = 110;
	localparam int unsigned RESP_SCAN_MS = 40;
	localparam int unsigned SCANS_MIN = 2;
	localparam int unsigned SCANS_MAX = 16;
	localparam int unsigned RESP_VEHICLE_MS = 270;
	// restart actuation level timing
	localparam int unsigned ACT_LOW_MIN_MS = 160;
	localparam int unsigned ACT_HIGH_MIN_MS = 240;
	localparam int unsigned ACT_HIGH_MAX_MS = 5000;
	localparam int unsigned ACT_LOW_MIN_CYC = ACT_LOW_MIN_MS * MS_CYCLES;
	localparam int unsigned ACT_HIGH_MIN_CYC = ACT_HIGH_MIN_MS * MS_CYCLES;
	localparam int unsigned ACT_HIGH_MAX_CYC = ACT_HIGH_MAX_MS * MS_CYCLES;
	// indicator flash half period
	localparam int unsigned FLASH_MS = 250;
	localparam int unsigned FLASH_CYC = FLASH_MS * MS_CYCLES;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_DELAY = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_EVENT = 8'h0C;
	localparam logic [7:0] REG_MASK = 8'h10;
	localparam logic [7:0] REG_CASE = 8'h14;
	// control field positions
	localparam int CTRL_TEST_EN = 0;
	localparam int CTRL_MODE_LSB = 1;
	localparam int CTRL_VEHICLE = 3;
	localparam int CTRL_ANY_ORDER = 4;
	localparam int CTRL_SCANS_LSB = 8;
	localparam int CTRL_OUT_A_EN = 16;
	localparam int CTRL_OUT_B_EN = 17;
	localparam logic [31:0] CTRL_RESET = 32'h0003_0201;
	localparam logic [15:0] DELAY_RESET = 16'h0001;
	localparam logic [7:0] CASE_RESET = 8'h00;
	// case table field positions
	localparam int CASE_SPEED_LSB = 0;
	localparam int CASE_DIR_LSB = 2;
	localparam int CASE_NEXT_LSB = 4;
	// event bits
	localparam int EV_TEST_DONE = 0;
	localparam int EV_INTRUSION = 1;
	localparam int EV_ENABLE = 2;
	localparam int EV_BAD_ACT = 3;
	localparam int EV_BAD_CASE = 4;
	localparam int EV_WIDTH = 5;
	typedef enum logic [1:0] {
		RESTART_IMMEDIATE,
		RESTART_DELAYED,
		RESTART_BUTTON,
		RESTART_SPARE
	} restart_mode_t;
endpackage

// ==== sync_two_ff.sv ====
// sync_two_ff: two flip-flop synchroniser for a bus of asynchronous levels
// assumes inputs are static long enough to be sampled once
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			stage1 <= '0;
			syncOut <= '0;
		end else begin
			stage1 <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule
`default_nettype wire

// ==== restart_actuation_check.sv ====
// restart_actuation_check: validates low-high-low timing of a restart button
// assumes a synchronised button level on ref_clk
`timescale 1ns/1ps
`default_nettype none
module restart_actuation_check
	import interlock_pkg::*;
#(
	parameter int unsigned LOW_MIN = ACT_LOW_MIN_CYC,
	parameter int unsigned HIGH_MIN = ACT_HIGH_MIN_CYC,
	parameter int unsigned HIGH_MAX = ACT_HIGH_MAX_CYC
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic buttonLevel,
	output logic validPulse,
	output logic invalidPulse
);
	typedef enum logic [1:0] {
		ACT_PRE_LOW,
		ACT_HIGH,
		ACT_POST_LOW
	} act_state_t;
	act_state_t state;
	logic [27:0] count;
	logic prevLevel;
	wire rise = buttonLevel && !prevLevel;
	wire fall = !buttonLevel && prevLevel;
	wire preOk = count >= 28'(LOW_MIN);
	wire highOk = count >= 28'(HIGH_MIN);
	wire highLong = count >= 28'(HIGH_MAX);
	wire postOk = count >= 28'(LOW_MIN);
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state <= ACT_PRE_LOW;
			count <= '0;
			prevLevel <= 1'b0;
			validPulse <= 1'b0;
			invalidPulse <= 1'b0;
		end else begin
			prevLevel <= buttonLevel;
			validPulse <= 1'b0;
			invalidPulse <= 1'b0;
			count <= (rise || fall || count == '1) ? count : count + 28'd1;
			if (rise || fall) count <= '0;
			unique case (state)
			ACT_PRE_LOW: begin
				// a rise after too short a low is refused
				if (rise) begin
					state <= preOk ? ACT_HIGH : ACT_PRE_LOW;
					invalidPulse <= !preOk;
				end
			end
			ACT_HIGH: begin
				if (fall) begin
					state <= highOk && !highLong ? ACT_POST_LOW : ACT_PRE_LOW;
					invalidPulse <= !highOk || highLong;
				end else if (highLong) begin
					state <= ACT_PRE_LOW;
					invalidPulse <= 1'b1;
				end
			end
			ACT_POST_LOW: begin
				if (rise) begin
					state <= ACT_HIGH;
					invalidPulse <= 1'b1;
				end else if (postOk) begin
					state <= ACT_PRE_LOW;
					validPulse <= 1'b1;
				end
			end
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== safety_output_restart_interlock.sv ====
// safety_output_restart_interlock: gates two safety outputs through start-up
// test and restart behaviour, drives indicators, selects monitoring cases
// assumes field inputs and buttons come from pins; wishbone on ref_clk
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - control bit chooses whether a start-up test is required after reset.
// - with start-up test set, outputs stay off until the test passes.
// - test covers only sensors of the first monitoring case at power-up.
// - start-up test may involve one or two active sensors.
// - after reset both outputs off and both red indicators lit.
// - a sensor passes after reporting field occupied, then free again.
// - restart after intrusion is immediate, delayed, or button gated.
// - immediate mode enables output a response time after field free.
// - enabled output turns red indicator off and green indicator on.
// - delayed mode enables output after the preset delay expires fully.
// - button mode flashes the yellow indicator while awaiting the button.
// - button mode enables only on a valid actuation, never field alone.
// - response time is 110 ms plus 40 ms per scan, 2 to 16 scans.
// - vehicle variant uses a fixed 270 ms response time.
// - speed cases from encoder inputs, direction cases from binary inputs.
// - case changes may be allowed in any order, not only fixed sequence.
module safety_output_restart_interlock
	import interlock_pkg::*;
#(
	parameter int unsigned MS_CYC = MS_CYCLES,
	parameter int unsigned FLASH_HALF = FLASH_CYC
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] fieldOccupied,
	input wire logic restart_input_a,
	input wire logic restart_input_b,
	input wire logic [1:0] speedCase,
	input wire logic [1:0] directionCase,
	output logic safety_output_a,
	output logic safety_output_b,
	output logic [1:0] redIndicator,
	output logic [1:0] greenIndicator,
	output logic [1:0] restart_request_indicator,
	output logic [1:0] activeSensors,
	output logic [3:0] monitoringCase,
	output logic irq
);
	function automatic logic [31:0] ms_to_cyc(input logic [15:0] ms);
		ms_to_cyc = 32'(ms) * 32'(MS_CYC);
	endfunction
	function automatic logic [1:0] sensors_of(input logic [3:0] mcase);
		// direction 01 or 10 selects second sensor only, 11 both, zero means first only
		sensors_of = mcase[CASE_DIR_LSB +: 2] == 2'b00 ? 2'b01 :
			(mcase[CASE_DIR_LSB +: 2] == 2'b11 ? 2'b11 : 2'b10);
	endfunction

	logic [31:0] ctrl;
	logic [15:0] delaySec;
	logic [EV_WIDTH-1:0] events;
	logic [EV_WIDTH-1:0] mask;
	logic [7:0] caseCfg;
	logic [1:0] fieldSync, speedSync, dirSync, resSync;
	logic [1:0] actValid, actInvalid;

	sync_two_ff #(.WIDTH(8)) pinSync (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.asyncIn({fieldOccupied, speedCase, directionCase,
			restart_input_b, restart_input_a}),
		.syncOut({fieldSync, speedSync, dirSync, resSync})
	);
	restart_actuation_check #(
		.LOW_MIN(ACT_LOW_MIN_MS * MS_CYC),
		.HIGH_MIN(ACT_HIGH_MIN_MS * MS_CYC),
		.HIGH_MAX(ACT_HIGH_MAX_MS * MS_CYC)
	) checkA (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.buttonLevel(resSync[0]),
		.validPulse(actValid[0]),
		.invalidPulse(actInvalid[0])
	);
	restart_actuation_check #(
		.LOW_MIN(ACT_LOW_MIN_MS * MS_CYC),
		.HIGH_MIN(ACT_HIGH_MIN_MS * MS_CYC),
		.HIGH_MAX(ACT_HIGH_MAX_MS * MS_CYC)
	) checkB (
		.ref_clk(ref_clk),
		.resetn(resetn),
		.buttonLevel(resSync[1]),
		.validPulse(actValid[1]),
		.invalidPulse(actInvalid[1])
	);

	wire testEn = ctrl[CTRL_TEST_EN];
	wire restart_mode_t mode = restart_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
	wire vehicle = ctrl[CTRL_VEHICLE];
	wire anyOrder = ctrl[CTRL_ANY_ORDER];
	wire [4:0] scansRaw = ctrl[CTRL_SCANS_LSB +: 5];
	wire [1:0] outEn = ctrl[CTRL_OUT_B_EN:CTRL_OUT_A_EN];
	wire [4:0] scans = scansRaw < 5'(SCANS_MIN) ? 5'(SCANS_MIN) :
		(scansRaw > 5'(SCANS_MAX) ? 5'(SCANS_MAX) : scansRaw);
	wire [15:0] respMs = vehicle ? 16'(RESP_VEHICLE_MS) :
		16'(RESP_BASE_MS) + 16'(RESP_SCAN_MS) * 16'(scans);
	wire [31:0] respCyc = ms_to_cyc(respMs);
	// wide enough for the largest programmable delay
	wire [47:0] delayCyc = 48'(delaySec) * 48'(MS_CYC) * 48'd1000;
	wire [47:0] limitCyc = mode == RESTART_DELAYED ? delayCyc :
		48'(respCyc);

	// monitoring case selection
	wire [3:0] requestedCase = {dirSync, speedSync};
	wire [3:0] nextAllowed = caseCfg[CASE_NEXT_LSB +: 4];
	wire caseChange = requestedCase != monitoringCase;
	wire caseLegal = anyOrder || requestedCase == nextAllowed;
	// pins settle through the synchroniser before the first case is taken
	logic [1:0] settle;
	wire firstCase = settle == 2'd2;
	wire caseValid = settle == 2'd3;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) settle <= 2'd0;
		else if (!caseValid) settle <= settle + 2'd1;
	end
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) monitoringCase <= 4'h0;
		else if (firstCase) monitoringCase <= requestedCase;
		else if (caseValid && caseChange && caseLegal)
			monitoringCase <= requestedCase;
	end
	assign activeSensors = sensors_of(monitoringCase);

	// start-up test
	logic testStarted, testPassed;
	logic [1:0] testSensors, sawOccupied, sensorDone;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			testStarted <= 1'b0;
			testPassed <= 1'b0;
			testSensors <= 2'b00;
			sawOccupied <= 2'b00;
			sensorDone <= 2'b00;
		end else begin
			if (!testStarted) begin
				testStarted <= caseValid;
				testSensors <= activeSensors;
			end else if (!testPassed) begin
				for (int i = 0; i < 2; i++) begin
					if (fieldSync[i]) sawOccupied[i] <= 1'b1;
					if (sawOccupied[i] && !fieldSync[i])
						sensorDone[i] <= 1'b1;
				end
				if ((sensorDone & testSensors) == testSensors)
					testPassed <= 1'b1;
			end
		end
	end
	wire ready = testStarted && (!testEn || testPassed);

	// flash generator
	logic [27:0] flashCnt;
	logic flash;
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			flashCnt <= '0;
			flash <= 1'b0;
		end else if (flashCnt >= 28'(FLASH_HALF - 1)) begin
			flashCnt <= '0;
			flash <= !flash;
		end else flashCnt <= flashCnt + 28'd1;
	end

	// per-output restart interlock
	typedef enum logic [1:0] {
		OUT_BLOCKED,
		OUT_WAIT_TIME,
		OUT_WAIT_BUTTON,
		OUT_ENABLED
	} out_state_t;
	out_state_t outState [2];
	logic [47:0] waitCnt [2];
	logic [1:0] outOn, enEvent, intrEvent;
	wire fieldBusy = |(fieldSync & activeSensors);
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < 2; i++) begin
				outState[i] <= OUT_BLOCKED;
				waitCnt[i] <= '0;
			end
			enEvent <= 2'b00;
			intrEvent <= 2'b00;
		end else begin
			enEvent <= 2'b00;
			intrEvent <= 2'b00;
			for (int i = 0; i < 2; i++) begin
				waitCnt[i] <= waitCnt[i] + 48'd1;
				if (!outEn[i] || !ready) begin
					outState[i] <= OUT_BLOCKED;
				end else if (fieldBusy) begin
					if (outState[i] != OUT_BLOCKED) intrEvent[i] <= 1'b1;
					outState[i] <= OUT_BLOCKED;
				end else begin
					unique case (outState[i])
					OUT_BLOCKED: begin
						waitCnt[i] <= '0;
						outState[i] <= mode == RESTART_BUTTON ?
							OUT_WAIT_BUTTON : OUT_WAIT_TIME;
					end
					OUT_WAIT_TIME: begin
						if (waitCnt[i] + 48'd1 >= limitCyc) begin
							outState[i] <= OUT_ENABLED;
							enEvent[i] <= 1'b1;
						end
					end
					OUT_WAIT_BUTTON: begin
						if (actValid[i]) begin
							outState[i] <= OUT_ENABLED;
							enEvent[i] <= 1'b1;
						end
					end
					OUT_ENABLED: ;
					endcase
				end
			end
		end
	end
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			outOn[i] = outState[i] == OUT_ENABLED;
			restart_request_indicator[i] =
				outState[i] == OUT_WAIT_BUTTON && flash;
		end
	end
	assign safety_output_a = outOn[0];
	assign safety_output_b = outOn[1];
	assign greenIndicator = outOn;
	assign redIndicator = ~outOn;

	// register bus
	wire access = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wr = access && wb_we_i;
	wire rdEvent = access && !wb_we_i && wb_adr_i == REG_EVENT;
	wire [EV_WIDTH-1:0] newEvents;
	assign newEvents[EV_TEST_DONE] = testEn && testStarted && !testPassed &&
		(sensorDone & testSensors) == testSensors;
	assign newEvents[EV_INTRUSION] = |intrEvent;
	assign newEvents[EV_ENABLE] = |enEvent;
	assign newEvents[EV_BAD_ACT] = |actInvalid;
	assign newEvents[EV_BAD_CASE] = caseValid && caseChange && !caseLegal;
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] sel);
		for (int b = 0; b < 4; b++)
			merge[b*8 +: 8] = sel[b] ? data[b*8 +: 8] : old[b*8 +: 8];
	endfunction
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl <= CTRL_RESET;
			delaySec <= DELAY_RESET;
			mask <= '0;
			caseCfg <= CASE_RESET;
			events <= '0;
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= access;
			// set wins over read-clear
			events <= (rdEvent ? '0 : events) | newEvents;
			if (wr && wb_adr_i == REG_CTRL)
				ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
			if (wr && wb_adr_i == REG_DELAY)
				delaySec <= 16'(merge({16'h0, delaySec}, wb_dat_i, wb_sel_i));
			if (wr && wb_adr_i == REG_MASK)
				mask <= EV_WIDTH'(merge(32'(mask), wb_dat_i, wb_sel_i));
			if (wr && wb_adr_i == REG_CASE)
				caseCfg <= 8'(merge(32'(caseCfg), wb_dat_i, wb_sel_i));
		end
	end
	wire [31:0] statusWord = {20'h0, monitoringCase, activeSensors,
		testPassed, ready, restart_request_indicator, outOn};
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) wb_dat_o <= 32'h0000_0000;
		else if (access && !wb_we_i) begin
			unique case (wb_adr_i)
			REG_CTRL: wb_dat_o <= ctrl;
			REG_DELAY: wb_dat_o <= {16'h0, delaySec};
			REG_STATUS: wb_dat_o <= statusWord;
			REG_EVENT: wb_dat_o <= 32'(events);
			REG_MASK: wb_dat_o <= 32'(mask);
			REG_CASE: wb_dat_o <= {24'h0, caseCfg};
			default: wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end
	assign irq = |(events & mask);
endmodule
`default_nettype wire

// ==== interlock_properties.sv ====
// interlock_properties: port-level checks of the output interlock
// assumes it is bound into safety_output_restart_interlock
`timescale 1ns/1ps
`default_nettype none
module interlock_properties #(
	parameter int unsigned MS_CYC = 20
) (
	input wire logic ref_clk,
	input wire logic resetn,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic [1:0] fieldOccupied,
	input wire logic safety_output_a,
	input wire logic safety_output_b,
	input wire logic [1:0] redIndicator,
	input wire logic [1:0] greenIndicator,
	input wire logic [1:0] restart_request_indicator,
	input wire logic [1:0] activeSensors,
	input wire logic [3:0] monitoringCase,
	input wire logic irq
);
	localparam int unsigned MIN_RESP = 190 * MS_CYC;
	logic [31:0] freeCnt;
	wire logic hit = |(fieldOccupied & activeSensors);
	// cycles since an active field was last seen occupied
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			freeCnt <= '0;
		else if (hit)
			freeCnt <= '0;
		else if (freeCnt != '1)
			freeCnt <= freeCnt + 1;
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("request not acked next cycle");
	property p_ack_one;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_one: assert property (p_ack_one)
		else $error("ack longer than one cycle");
	property p_lamps;
		greenIndicator == {safety_output_b, safety_output_a}
			&& redIndicator == ~greenIndicator;
	endproperty
	a_lamps: assert property (p_lamps)
		else $error("lamps disagree with outputs");
	property p_reset;
		!$past(resetn) |-> !safety_output_a && !safety_output_b
			&& redIndicator == 2'b11;
	endproperty
	a_reset: assert property (p_reset)
		else $error("outputs not off after reset");
	property p_drop;
		$rose(hit) |-> ##[1:4] !safety_output_a;
	endproperty
	a_drop: assert property (p_drop)
		else $error("output kept on with field occupied");
	property p_yellow;
		restart_request_indicator[0] |-> !safety_output_a;
	endproperty
	a_yellow: assert property (p_yellow)
		else $error("output on while awaiting button");
	property p_min_resp;
		$rose(safety_output_a) |-> freeCnt >= MIN_RESP;
	endproperty
	a_min_resp: assert property (p_min_resp)
		else $error("output enabled before response time");
	property p_sensors;
		activeSensors == (monitoringCase[3:2] == 2'b11 ? 2'b11 :
			monitoringCase[3:2] == 2'b00 ? 2'b01 : 2'b10);
	endproperty
	a_sensors: assert property (p_sensors)
		else $error("active sensors do not match case");
	c_enable: cover property ($rose(safety_output_a));
	c_wait: cover property ($rose(restart_request_indicator[0]));
	c_irq: cover property ($rose(irq));
endmodule
bind safety_output_restart_interlock interlock_properties #(
	.MS_CYC(MS_CYC)
) u_props (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_ack_o(wb_ack_o),
	.fieldOccupied(fieldOccupied),
	.safety_output_a(safety_output_a),
	.safety_output_b(safety_output_b),
	.redIndicator(redIndicator),
	.greenIndicator(greenIndicator),
	.restart_request_indicator(restart_request_indicator),
	.activeSensors(activeSensors),
	.monitoringCase(monitoringCase),
	.irq(irq)
);
`default_nettype wire

// ==== scanner_partner.sv ====
// scanner_partner: behavioural field sensors and restart buttons a and b
// assumes the bench calls its tasks; levels change after ref_clk edges
`timescale 1ns/1ps
`default_nettype none
module scanner_partner (
	input wire logic ref_clk,
	output logic [1:0] fieldOccupied,
	output logic restartA,
	output logic restartB
);
	initial begin
		fieldOccupied = 2'b00;
		restartA = 1'b0;
		restartB = 1'b0;
	end
	// field occupied for n cycles, then free again
	task automatic intrude(input int s, input int n);
		@(posedge ref_clk);
		fieldOccupied[s] <= 1'b1;
		repeat (n) @(posedge ref_clk);
		fieldOccupied[s] <= 1'b0;
	endtask
	// button s high for hi cycles, low before and after
	task automatic press(input int s, input int hi);
		@(posedge ref_clk);
		if (s == 0) restartA <= 1'b1;
		else restartB <= 1'b1;
		repeat (hi) @(posedge ref_clk);
		if (s == 0) restartA <= 1'b0;
		else restartB <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== safety_output_restart_interlock_tb.sv ====
// safety_output_restart_interlock_tb: self-checking bench
// assumes a shortened millisecond of 20 cycles
`timescale 1ns/1ps
`default_nettype none
module safety_output_restart_interlock_tb;
	import interlock_pkg::*;
	localparam int MSC = 20;
	logic ref_clk, resetn, cyc, stb, we, ack, irq, outA, outB;
	logic restartA, restartB;
	logic [7:0] adr;
	logic [3:0] sel, mcase;
	logic [31:0] dat, rdat, q;
	logic [1:0] speedCase, directionCase, fieldOccupied;
	logic [1:0] red, green, yellow, sens;
	int failures, cmpCount;
	safety_output_restart_interlock #(.MS_CYC(MSC), .FLASH_HALF(50)) dut (
		.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.fieldOccupied(fieldOccupied), .restart_input_a(restartA),
		.restart_input_b(restartB), .speedCase(speedCase),
		.directionCase(directionCase), .safety_output_a(outA),
		.safety_output_b(outB), .redIndicator(red),
		.greenIndicator(green), .restart_request_indicator(yellow),
		.activeSensors(sens), .monitoringCase(mcase), .irq(irq));
	scanner_partner partner (.ref_clk(ref_clk),
		.fieldOccupied(fieldOccupied), .restartA(restartA),
		.restartB(restartB));
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmpCount++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		chk({31'h0, n < 20}, 32'h1);
	endtask
	function automatic logic [31:0] ctrl(input logic [1:0] m,
		input logic v, input logic any, input logic [4:0] s);
		logic [31:0] c;
		c = 32'h0003_0001;
		c[CTRL_MODE_LSB +: 2] = m;
		c[CTRL_VEHICLE] = v;
		c[CTRL_ANY_ORDER] = any;
		c[CTRL_SCANS_LSB +: 5] = s;
		return c;
	endfunction
	task automatic wait_on(input int lo, input int hi);
		int n;
		n = 0;
		while (outA !== 1'b1 && n <= hi) begin
			@(posedge ref_clk);
			n++;
		end
		chk({31'h0, n >= lo && n <= hi}, 32'h1);
		chk({28'h0, green, red}, 32'hC);
	endtask
	task automatic t_reset;
		chk({28'h0, outA, outB, red}, 32'h3);
		chk({30'h0, green}, 32'h0);
		wb(1'b0, REG_CTRL, 32'h0);
		chk(q, CTRL_RESET);
		wb(1'b0, REG_DELAY, 32'h0);
		chk(q, {16'h0, DELAY_RESET});
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_startup;
		partner.intrude(0, 40);
		repeat (4200) @(posedge ref_clk);
		chk({31'h0, outA}, 32'h0);
		partner.intrude(1, 40);
		wait_on(3800, 3812);
		wb(1'b1, REG_MASK, 32'h4);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h1);
		wb(1'b0, REG_EVENT, 32'h0);
		chk(q & 32'h5, 32'h5);
		repeat (3) @(posedge ref_clk);
		chk({31'h0, irq}, 32'h0);
		$display("test startup done");
	endtask
	task automatic t_resp;
		int rt;
		for (int i = 0; i < 3; i++) begin
			rt = (RESP_BASE_MS + RESP_SCAN_MS * (i == 1 ? 16 : 2)) * MSC;
			if (i == 2)
				rt = RESP_VEHICLE_MS * MSC;
			wb(1'b1, REG_CTRL, ctrl(2'd0, i == 2, 1'b0,
				i == 1 ? 5'd16 : 5'd2));
			partner.intrude(0, 20);
			chk({31'h0, outA}, 32'h0);
			wait_on(rt, rt + 12);
		end
		$display("test response done");
	endtask
	task automatic t_delay;
		wb(1'b1, REG_DELAY, 32'h1);
		wb(1'b1, REG_CTRL, ctrl(2'd1, 1'b0, 1'b0, 5'd2));
		partner.intrude(1, 20);
		wait_on(1000 * MSC, 1000 * MSC + 12);
		$display("test delay done");
	endtask
	task automatic t_button;
		int tog;
		logic y;
		wb(1'b1, REG_CTRL, ctrl(2'd2, 1'b0, 1'b0, 5'd2));
		partner.intrude(0, 20);
		tog = 0;
		y = yellow[0];
		repeat (250) begin
			@(posedge ref_clk);
			if (yellow[0] !== y)
				tog++;
			y = yellow[0];
		end
		chk({31'h0, tog >= 3}, 32'h1);
		partner.press(0, 60);
		repeat (100) @(posedge ref_clk);
		chk({30'h0, outA, outB}, 32'h0);
		// legal low, high and low spans on both buttons
		repeat (3300) @(posedge ref_clk);
		fork
			partner.press(0, 5000);
			partner.press(1, 5000);
		join
		wait_on(3200, 3212);
		$display("test button done");
	endtask
	task automatic t_case;
		wb(1'b1, REG_CTRL, ctrl(2'd0, 1'b0, 1'b1, 5'd2));
		speedCase <= 2'b10;
		directionCase <= 2'b01;
		repeat (8) @(posedge ref_clk);
		chk({26'h0, sens, mcase}, 32'h26);
		wb(1'b1, REG_CTRL, ctrl(2'd0, 1'b0, 1'b0, 5'd2));
		speedCase <= 2'b01;
		repeat (8) @(posedge ref_clk);
		wb(1'b0, REG_EVENT, 32'h0);
		chk({31'h0, q[EV_BAD_CASE]}, 32'h1);
		wb(1'b1, REG_CASE, 32'h50);
		repeat (4) @(posedge ref_clk);
		chk({28'h0, mcase}, 32'h5);
		$display("test case done");
	endtask
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmpCount, failures);
		if (failures == 0 && cmpCount > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge ref_clk);
		failures++;
		$display("[ERR] %0t watchdog expired", $time);
		end_sim;
	end
	initial begin
		failures = 0;
		cmpCount = 0;
		resetn = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'hF;
		dat = 32'h0;
		speedCase = 2'b00;
		directionCase = 2'b11;
		repeat (10) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		t_reset;
		t_startup;
		t_resp;
		t_delay;
		t_button;
		t_case;
		end_sim;
	end
endmodule
`default_nettype wire
